// >>> verilog/fieldbus_node_pkg.sv
/*
 * Constants, enums and carrier structs of the fieldbus node block.
 * Assumes one clock and a synchronous active-high reset.
 */
// How it works
// RULE1 - DeviceNet address 0..63 from switches, default 63
// RULE2 - Sample once, write storage if changed
// RULE3 - DeviceNet setting above 63 keeps previous address
// RULE4 - Programmable upper digit: master assigns address
// RULE5 - Rate switch 1/2/5 gives 125/250/500, default 500
// RULE6 - Programmable rate switch: master sets bit rate
// RULE7 - Idle after power-up, sends safe value
// RULE8 - Start or exchange enters executing; live data
// RULE9 - Module lamp shows self-test, normal, error kinds
// RULE10 - Network lamp shows online, connected, timeout
// RULE11 - Network lamp solid red on blocking fault
// RULE12 - Profibus address 0..125 from hex switches, fixed
// RULE13 - Above 7D starts at 126, master assigns
// RULE14 - Lock attribute blocks further address changes
// RULE15 - Assigned address, lock stored; low switch erases
// RULE16 - EtherCAT three hex switches give reported identity
// RULE17 - Factory zero switches give identity zero
// RULE18 - Profinet exchanges only after being named
// RULE19 - Later switch changes ignored until power cycle
package fieldbus_node_pkg;

    // =========================================================
    // Register map
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_SETADDR  = 8'h04;
    localparam logic [7:0] REG_RATEPROG = 8'h08;
    localparam logic [7:0] REG_SAFE     = 8'h0C;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_IDENT    = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;

    // Control register bit positions.
    localparam int CTRL_START    = 0;
    localparam int CTRL_EXCHANGE = 1;
    localparam int CTRL_SELFTEST = 2;
    localparam int CTRL_NAMED    = 3;
    localparam int CTRL_CONN     = 4;
    localparam int CTRL_TIMEOUT  = 5;
    localparam int CTRL_FAULT    = 6;
    localparam int CTRL_RECOV    = 7;
    localparam int CTRL_UNRECOV  = 8;
    localparam int CTRL_W        = 9;
    localparam int SA_LOCK_BIT   = 8;

    // Interrupt event bit positions.
    localparam int IRQ_EXEC     = 0;
    localparam int IRQ_ASSIGNED = 1;
    localparam int IRQ_REJECT   = 2;
    localparam int IRQ_REFUSED  = 3;
    localparam int IRQ_W        = 4;

    // =========================================================
    // Switch decoding and timing
    localparam logic [3:0] SW_PROG      = 4'hF;
    localparam logic [3:0] RATE_POS_125 = 4'h1;
    localparam logic [3:0] RATE_POS_250 = 4'h2;
    localparam logic [3:0] RATE_POS_500 = 4'h5;
    localparam logic [7:0] DEC_TEN      = 8'h0A;
    localparam logic [7:0] DN_MAX_ADDR  = 8'h3F;
    localparam logic [7:0] PB_MAX_ADDR  = 8'h7D;
    localparam logic [7:0] PB_START     = 8'h7E;
    localparam logic [1:0] SETTLE       = 2'h3;
    localparam int BLINK_HALF_MS = 500;
    localparam int CLK_KHZ       = 40000;
    localparam int BLINK_CYCLES  = BLINK_HALF_MS * CLK_KHZ;
    localparam int BLINK_W       = 25;

    typedef enum logic [1:0] {RATE_125 = 2'h0, RATE_250 = 2'h1, RATE_500 = 2'h2} rate_e;
    typedef enum logic [1:0] {VAR_DNET = 2'h0, VAR_PBUS = 2'h1,
                              VAR_ECAT = 2'h2, VAR_PNET = 2'h3} var_e;
    typedef enum logic [1:0] {S_SETTLE = 2'h0, S_SAMPLE = 2'h1,
                              S_IDLE = 2'h3, S_EXEC = 2'h2} fsm_e;

    typedef struct packed {logic green; logic red;} lamp_s;

    typedef struct packed {
        logic [3:0] upper, lower, rate, hund, tens, units;
        var_e       variant;
    } switch_s;

    typedef struct packed {
        logic [13:0] rsv;
        logic [7:0]  node;
        logic        lock, rate_prog, addr_prog, live;
        rate_e       rate;
        var_e        variant;
        fsm_e        state;
    } status_s;

endpackage

// >>> verilog/fieldbus_node_config_status.sv
/*
 * Fieldbus node setup and status: one switch sample, range checks, store
 * upkeep, idle/executing gate and lamps.
 * Assumes async switch pins and firmware events over the register port.
 */
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/10ps

module fieldbus_node_config_status #(
    parameter int BLINK_CYCLES = fieldbus_node_pkg::BLINK_CYCLES
) (
    input  wire logic                      clk,                // 40 MHz clock.
    input  wire logic                      rst,                // Sync reset.
    input  wire fieldbus_node_pkg::var_e   variant_strap,      // Bus variant pins.
    input  wire logic [3:0]                upper_digit_switch, // Upper digit.
    input  wire logic [3:0]                lower_digit_switch, // Lower digit.
    input  wire logic [3:0]                rate_switch,        // Rate switch.
    input  wire logic [3:0]                hundreds_hex_switch, // Id hundreds_hex_switch.
    input  wire logic [3:0]                tens_hex_switch,    // Id x10.
    input  wire logic [3:0]                units_hex_switch,   // Id x1.
    input  wire logic                      nv_valid,           // Store holds data.
    input  wire logic [7:0]                nv_node_addr,       // Stored address.
    input  wire logic                      nv_lock,            // Stored lock.
    output logic                           nv_wr,              // Store write pulse.
    output logic [7:0]                     nv_wr_addr,         // Address to store.
    output logic                           nv_wr_lock,         // Lock to store.
    output logic                           nv_erase,           // Erase pulse.
    input  wire logic [15:0]               meas_value,         // Pressure value.
    output logic [15:0]                    tx_value,           // Value sent out.
    output logic                           tx_live,            // Executing.
    output logic [7:0]                     node_addr,          // Node address.
    output fieldbus_node_pkg::rate_e       bit_rate,           // Bit rate.
    input  wire logic [7:0]                reg_addr,           // Register address.
    input  wire logic [31:0]               reg_wdata,          // Write data.
    input  wire logic                      reg_wr,             // Write strobe.
    input  wire logic                      reg_rd,             // Read strobe.
    output logic [31:0]                    reg_rdata,          // Read data.
    output logic                           irq,                // Interrupt level.
    output fieldbus_node_pkg::lamp_s       module_state_lamp,  // Module lamp.
    output fieldbus_node_pkg::lamp_s       network_state_lamp  // Network lamp.
);
    import fieldbus_node_pkg::*;

    // =========================================================
    // State of the block
    typedef struct packed {
        switch_s              sw1;
        switch_s              sw2;
        fsm_e                 state;
        logic [1:0]           settle;
        var_e                 variant;
        logic [7:0]           node;
        rate_e                rate;
        logic                 addr_prog;
        logic                 rate_prog;
        logic                 lock;
        logic [11:0]          ident;
        logic [CTRL_W-1:0]    ctrl;
        logic [15:0]          safe;
        logic [15:0]          tx;
        logic                 live;
        logic [IRQ_W-1:0]     irq_stat;
        logic [IRQ_W-1:0]     irq_mask;
        logic [31:0]          rdata;
        logic [BLINK_W-1:0]   blink_cnt;
        logic                 blink;
        lamp_s                mod_lamp;
        lamp_s                net_lamp;
        logic                 nv_wr;
        logic [7:0]           nv_addr;
        logic                 nv_lock;
        logic                 nv_erase;
    } core_s;

    core_s q;
    core_s next_q;

    // =========================================================
    // Next-state logic
    // The whole block is one combinational update of the state copy.
    always_comb begin
        logic [7:0]        dec_addr;
        logic [7:0]        hex_addr;
        logic [7:0]        kept_addr;
        logic [IRQ_W-1:0]  ev;
        logic [IRQ_W-1:0]  clr;
        logic              selftest;
        logic              may_run;
        status_s           st;
        dec_addr  = 8'h00;
        hex_addr  = 8'h00;
        kept_addr = 8'h00;
        ev        = '0;
        clr       = '0;
        selftest  = 1'b0;
        may_run   = 1'b0;
        st        = '0;
        next_q    = q;

        // Switch pins pass two flops; only the second stage is read.
        next_q.sw1 = '{upper: upper_digit_switch, lower: lower_digit_switch,
                       rate: rate_switch, hund: hundreds_hex_switch,
                       tens: tens_hex_switch, units: units_hex_switch,
                       variant: variant_strap};
        next_q.sw2 = q.sw1;

        // Pulses last one cycle unless raised again below.
        next_q.nv_wr    = 1'b0;
        next_q.nv_erase = 1'b0;
        next_q.rdata    = 32'h0000_0000;
        next_q.ctrl[CTRL_START] = 1'b0;

        // Decimal and hex readings of the two address digits.
        dec_addr  = ({4'h0, q.sw2.upper} * DEC_TEN) + {4'h0, q.sw2.lower};
        hex_addr  = {q.sw2.upper, q.sw2.lower};
        kept_addr = nv_valid ? nv_node_addr : DN_MAX_ADDR;

        // =====================================================
        // Sequencer
        // Switches are decoded in one pass only; later changes go unseen.
        case (q.state)
            S_SETTLE: begin
                if (q.settle == SETTLE) begin
                    next_q.state = S_SAMPLE;
                end else begin
                    next_q.settle = q.settle + 2'h1;
                end
            end
            S_SAMPLE: begin
                next_q.variant = q.sw2.variant;                   // [RULE19]
                next_q.state   = S_IDLE;                          // [RULE7]
                case (q.sw2.variant)
                    VAR_DNET: begin
                        // Unknown positions fall back to the fastest rate.
                        case (q.sw2.rate)                         // [RULE5]
                            RATE_POS_125: next_q.rate = RATE_125;
                            RATE_POS_250: next_q.rate = RATE_250;
                            RATE_POS_500: next_q.rate = RATE_500;
                            SW_PROG: begin
                                next_q.rate      = RATE_500;
                                next_q.rate_prog = 1'b1;          // [RULE6]
                            end
                            default: next_q.rate = RATE_500;
                        endcase
                        if (q.sw2.upper == SW_PROG) begin
                            next_q.addr_prog = 1'b1;              // [RULE4]
                            next_q.node      = kept_addr;
                        end else if (dec_addr > DN_MAX_ADDR) begin
                            next_q.node  = kept_addr;             // [RULE3]
                            ev[IRQ_REJECT] = 1'b1;
                        end else begin
                            next_q.node = dec_addr;               // [RULE1]
                            if (!nv_valid || nv_node_addr != dec_addr) begin
                                next_q.nv_wr   = 1'b1;            // [RULE2]
                                next_q.nv_addr = dec_addr;
                                next_q.nv_lock = 1'b0;
                            end
                        end
                    end
                    VAR_PBUS: begin
                        if (hex_addr <= PB_MAX_ADDR) begin
                            next_q.node     = hex_addr;           // [RULE12]
                            next_q.lock     = 1'b0;
                            next_q.nv_erase = 1'b1;               // [RULE15]
                        end else begin
                            next_q.addr_prog = 1'b1;              // [RULE13]
                            next_q.node = nv_valid ? nv_node_addr : PB_START;
                            next_q.lock = nv_valid & nv_lock;     // [RULE15]
                        end
                    end
                    VAR_ECAT: begin
                        // Digit weights 0x100, 0x10, 0x1 are a plain concatenation.
                        next_q.ident = {q.sw2.hund, q.sw2.tens, q.sw2.units};
                    end                                           // [RULE16] [RULE17]
                    default: begin
                        next_q.node = 8'h00;
                    end
                endcase
            end
            S_IDLE: begin
                // Profinet may not exchange before it has a name.
                may_run = q.ctrl[CTRL_SELFTEST] & ~q.ctrl[CTRL_UNRECOV] &
                          ((q.variant != VAR_PNET) | q.ctrl[CTRL_NAMED]); // [RULE18]
                if (may_run && (q.ctrl[CTRL_START] || q.ctrl[CTRL_EXCHANGE])) begin
                    next_q.state = S_EXEC;                        // [RULE8]
                    ev[IRQ_EXEC] = 1'b1;
                end
            end
            S_EXEC: begin
                // A fatal error or a lost name drops back to the safe value.
                if (q.ctrl[CTRL_UNRECOV] ||
                    (q.variant == VAR_PNET && !q.ctrl[CTRL_NAMED])) begin
                    next_q.state = S_IDLE;                        // [RULE18]
                end
            end
            default: next_q.state = S_SETTLE;
        endcase

        // Live data only while executing, safe value otherwise.
        next_q.live = (q.state == S_EXEC);                        // [RULE8]
        next_q.tx   = (q.state == S_EXEC) ? meas_value : q.safe;  // [RULE7]

        // =====================================================
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: next_q.ctrl = reg_wdata[CTRL_W-1:0];
                REG_SETADDR: begin
                    // Refused unless the address is master-owned and unlocked.
                    if (q.addr_prog && !q.lock &&
                        (q.state == S_IDLE || q.state == S_EXEC) &&
                        reg_wdata[7:0] <= ((q.variant == VAR_PBUS) ?
                                           PB_MAX_ADDR : DN_MAX_ADDR)) begin
                        next_q.node    = reg_wdata[7:0];          // [RULE4] [RULE13]
                        next_q.lock    = (q.variant == VAR_PBUS) &
                                         reg_wdata[SA_LOCK_BIT];  // [RULE14]
                        next_q.nv_wr   = 1'b1;                    // [RULE15]
                        next_q.nv_addr = reg_wdata[7:0];
                        next_q.nv_lock = (q.variant == VAR_PBUS) &
                                         reg_wdata[SA_LOCK_BIT];
                        ev[IRQ_ASSIGNED] = 1'b1;
                    end else begin
                        ev[IRQ_REFUSED] = 1'b1;                   // [RULE12] [RULE14]
                    end
                end
                REG_RATEPROG: begin
                    if (q.rate_prog && reg_wdata[1:0] != 2'h3) begin
                        next_q.rate = rate_e'(reg_wdata[1:0]);    // [RULE6]
                    end
                end
                REG_SAFE:     next_q.safe     = reg_wdata[15:0];
                REG_IRQ_MASK: next_q.irq_mask = reg_wdata[IRQ_W-1:0];
                default:      next_q.safe     = q.safe;
            endcase
        end

        // =====================================================
        // Register reads, answered one cycle later
        st = '{rsv: '0, node: q.node, lock: q.lock, rate_prog: q.rate_prog,
               addr_prog: q.addr_prog, live: q.live, rate: q.rate,
               variant: q.variant, state: q.state};
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:     next_q.rdata = 32'(q.ctrl);
                REG_SETADDR:  next_q.rdata = 32'({q.lock, q.node});
                REG_RATEPROG: next_q.rdata = 32'(q.rate);
                REG_SAFE:     next_q.rdata = 32'(q.safe);
                REG_STATUS:   next_q.rdata = st;
                REG_IDENT:    next_q.rdata = 32'(q.ident);        // [RULE16]
                REG_IRQ_STAT: begin
                    next_q.rdata = 32'(q.irq_stat);
                    clr = q.irq_stat;
                end
                REG_IRQ_MASK: next_q.rdata = 32'(q.irq_mask);
                default:      next_q.rdata = 32'h0000_0000;
            endcase
        end

        // A new event in the clearing cycle survives the read.
        next_q.irq_stat = (q.irq_stat & ~clr) | ev;

        // =====================================================
        // Lamps
        // Blink phase is shared so both lamps flash together.
        if (q.blink_cnt == BLINK_W'(BLINK_CYCLES - 1)) begin
            next_q.blink_cnt = '0;
            next_q.blink     = ~q.blink;
        end else begin
            next_q.blink_cnt = q.blink_cnt + 1'b1;
        end

        selftest = (q.state != S_IDLE && q.state != S_EXEC) |
                   ~q.ctrl[CTRL_SELFTEST];

        // Errors outrank self-test so a fatal fault is never masked.
        if (q.ctrl[CTRL_UNRECOV]) begin
            next_q.mod_lamp = '{green: 1'b0, red: 1'b1};          // [RULE9]
        end else if (q.ctrl[CTRL_RECOV]) begin
            next_q.mod_lamp = '{green: 1'b0, red: q.blink};       // [RULE9]
        end else if (selftest) begin
            next_q.mod_lamp = '{green: q.blink, red: ~q.blink};   // [RULE9]
        end else begin
            next_q.mod_lamp = '{green: 1'b1, red: 1'b0};          // [RULE9]
        end

        if (selftest) begin
            next_q.net_lamp = '{green: 1'b0, red: 1'b0};          // [RULE10]
        end else if (q.ctrl[CTRL_FAULT]) begin
            next_q.net_lamp = '{green: 1'b0, red: 1'b1};          // [RULE11]
        end else if (q.ctrl[CTRL_TIMEOUT]) begin
            next_q.net_lamp = '{green: 1'b0, red: q.blink};       // [RULE10]
        end else if (q.ctrl[CTRL_CONN]) begin
            next_q.net_lamp = '{green: 1'b1, red: 1'b0};          // [RULE10]
        end else begin
            next_q.net_lamp = '{green: q.blink, red: 1'b0};       // [RULE10]
        end
    end

    // =========================================================
    // State register
    // Reset clears everything, which leaves the lamps dark as if unpowered.
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // =========================================================
    // Outputs
    // All data outputs come straight from flops; only the irq level is gated.
    assign nv_wr              = q.nv_wr;
    assign nv_wr_addr         = q.nv_addr;
    assign nv_wr_lock         = q.nv_lock;
    assign nv_erase           = q.nv_erase;
    assign tx_value           = q.tx;
    assign tx_live            = q.live;
    assign node_addr          = q.node;
    assign bit_rate           = q.rate;
    assign reg_rdata          = q.rdata;
    assign irq                = |(q.irq_stat & q.irq_mask);
    assign module_state_lamp  = q.mod_lamp;
    assign network_state_lamp = q.net_lamp;

endmodule

// >>> tb/fieldbus_node_checker.sv
/* Port assertions of the fieldbus node block.
   Assumes binding into that block. */
`timescale 1ns/10ps
// ==========
// Checker
module fieldbus_node_checker (
    input wire logic                    clk,                // Clock.
    input wire logic                    rst,                // Reset.
    input wire fieldbus_node_pkg::var_e variant_strap,      // Variant.
    input wire logic                    reg_rd,             // Read strobe.
    input wire logic [31:0]             reg_rdata,          // Read data.
    input wire logic [15:0]             meas_value,         // Measurement.
    input wire logic [15:0]             tx_value,           // Sent value.
    input wire logic                    tx_live,            // Executing.
    input wire logic                    nv_wr,              // Store write.
    input wire logic [7:0]              nv_wr_addr,         // Stored address.
    input wire logic                    nv_erase,           // Store erase.
    input wire logic [7:0]              node_addr,          // Node address.
    input wire fieldbus_node_pkg::rate_e bit_rate,          // Bit rate.
    input wire fieldbus_node_pkg::lamp_s module_state_lamp, // Module lamp.
    input wire fieldbus_node_pkg::lamp_s network_state_lamp // Network lamp.
);
    import fieldbus_node_pkg::*;
    // One domain, so clock and reset are given once for all assertions.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_read_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_live_data: assert property (tx_live && $past(tx_live) |-> tx_value == $past(meas_value))
        else $error("live value not the measurement");
    a_store_pulse: assert property (nv_wr |=> !nv_wr)
        else $error("store write longer than one cycle");
    a_store_hold: assert property (nv_wr |=> $stable(nv_wr_addr))
        else $error("store address moved after write");
    a_erase_pulse: assert property (nv_erase |=> !nv_erase)
        else $error("erase longer than one cycle");
    a_dn_range: assert property (variant_strap == VAR_DNET |-> node_addr <= DN_MAX_ADDR)
        else $error("address out of range");
    a_pb_range: assert property (variant_strap == VAR_PBUS |-> node_addr <= PB_START)
        else $error("address out of range");
    a_lamps_dark: assert property ($past(rst) |-> !tx_live &&
        {module_state_lamp, network_state_lamp} == 4'h0)
        else $error("output lit at reset exit");
    a_rate_legal: assert property (bit_rate != 2'h3)
        else $error("illegal rate code");
endmodule

bind fieldbus_node_config_status fieldbus_node_checker chk_u (.*);

// >>> tb/nv_store_model.sv
/* Non-volatile store beside the node block.
   Assumes one-cycle write and erase pulses on clk; contents outlive rst. */
`timescale 1ns/10ps
module nv_store_model (
    input  wire logic       clk,          // Clock.
    input  wire logic       nv_wr,        // Write pulse.
    input  wire logic [7:0] nv_wr_addr,   // Address in.
    input  wire logic       nv_wr_lock,   // Lock in.
    input  wire logic       nv_erase,     // Erase pulse.
    output logic            nv_valid,     // Holds data.
    output logic [7:0]      nv_node_addr, // Address out.
    output logic            nv_lock       // Lock out.
);
    // An erased word reads back inverted so a stale value cannot pass.
    initial nv_valid = 1'b0;
    initial nv_node_addr = 8'hA5;
    initial nv_lock = 1'b0;
    always @(posedge clk) begin
        if (nv_erase) begin
            nv_valid <= 1'b0;
            nv_node_addr <= ~nv_node_addr;
            nv_lock <= 1'b0;
        end else if (nv_wr) begin
            nv_valid <= 1'b1;
            nv_node_addr <= nv_wr_addr;
            nv_lock <= nv_wr_lock;
        end
    end
endmodule

// >>> tb/fieldbus_node_config_status_test.sv
/* Bench of the fieldbus node block.
   Assumes the bench is the register master. */
`timescale 1ns/10ps
module fieldbus_node_config_status_test;
    import fieldbus_node_pkg::*;
    logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    var_e        vs = VAR_DNET;
    logic [3:0]  up = 0, lo = 0, rs = 0, hu = 0, te = 0, un = 0;
    logic        nv_valid, nv_lock, nv_wr, nv_wr_lock, nv_erase, tx_live, irq;
    logic [7:0]  nv_node_addr, nv_wr_addr, node_addr, reg_addr = 0;
    logic [15:0] tx_value, mv = 16'h0;
    logic [31:0] reg_rdata, reg_wdata = 0, d;
    rate_e       bit_rate;
    lamp_s       ml, nl;
    int          bad_count = 0, checks_done = 0, cycles = 0;
    fieldbus_node_config_status #(.BLINK_CYCLES(8)) dut_u (.clk(clk), .rst(rst),
        .variant_strap(vs), .upper_digit_switch(up), .lower_digit_switch(lo),
        .rate_switch(rs), .hundreds_hex_switch(hu), .tens_hex_switch(te),
        .units_hex_switch(un), .nv_valid(nv_valid), .nv_node_addr(nv_node_addr),
        .nv_lock(nv_lock), .nv_wr(nv_wr), .nv_wr_addr(nv_wr_addr), .nv_wr_lock(nv_wr_lock),
        .nv_erase(nv_erase), .meas_value(mv), .tx_value(tx_value), .tx_live(tx_live),
        .node_addr(node_addr), .bit_rate(bit_rate), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .module_state_lamp(ml), .network_state_lamp(nl));
    nv_store_model store_u (.clk(clk), .nv_wr(nv_wr), .nv_wr_addr(nv_wr_addr),
        .nv_wr_lock(nv_wr_lock), .nv_erase(nv_erase), .nv_valid(nv_valid),
        .nv_node_addr(nv_node_addr), .nv_lock(nv_lock));
    // ==========
    // Clock, hang guard and shared tasks.
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        mv <= mv + 16'h1;
        if (cycles == 6000) begin
            bad_count++;
            test_done();
        end
    end
    task test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Switches are set under reset; sampling then gets time.
    task boot(input var_e v, input logic [3:0] u, l, r);
        @(posedge clk);
        rst <= 1'b1; vs <= v; up <= u; lo <= l; rs <= r;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        pause(12);
    endtask
    // ==========
    // Scenarios.
    initial begin
        boot(VAR_DNET, 4'h6, 4'h3, 4'h1);
        chk(node_addr, 8'h3F);
        chk(bit_rate, RATE_125);
        chk(nv_node_addr, 8'h3F);
        wr(REG_SAFE, 32'h1234); pause(2);
        chk(tx_value, 16'h1234);
        wr(REG_IRQ_MASK, 32'h1); wr(REG_CTRL, 32'h5); pause(3);
        chk({tx_live, tx_value}, {1'b1, mv - 16'h1});
        chk(irq, 1'b1);
        rd(REG_IRQ_STAT); chk({irq, d[0]}, 2'b01);
        chk(ml, 2'b10);
        wr(REG_CTRL, 32'h14); pause(2); chk(nl, 2'b10);
        wr(REG_CTRL, 32'h54); pause(2); chk(nl, 2'b01);
        wr(REG_CTRL, 32'hB4); pause(2); chk({ml.green, nl.green}, 2'b00);
        wr(REG_CTRL, 32'h114); pause(3); chk({ml, tx_live}, 3'b010);
        chk(tx_value, 16'h1234);
        boot(VAR_DNET, 4'h1, 4'h2, 4'h2);
        chk({node_addr, nv_node_addr}, 16'h0C0C);
        chk(bit_rate, RATE_250);
        boot(VAR_DNET, 4'h7, 4'h0, 4'h5);
        chk({node_addr, bit_rate}, {8'h0C, RATE_500});
        rd(REG_IRQ_STAT); chk(d[2], 1'b1);
        lo <= 4'h5; pause(10); chk(node_addr, 8'h0C);
        boot(VAR_DNET, 4'hF, 4'h0, 4'hF);
        chk({node_addr, bit_rate}, {8'h0C, RATE_500});
        wr(REG_RATEPROG, 32'h0); pause(1); chk(bit_rate, RATE_125);
        wr(REG_SETADDR, 32'h5); pause(1); chk(node_addr, 8'h05);
        rd(8'hFC); chk(d, 32'h0);
        boot(VAR_PBUS, 4'h7, 4'hD, 4'h0);
        chk({node_addr, nv_valid}, 9'h0FA);
        wr(REG_SETADDR, 32'h3); pause(1); chk(node_addr, 8'h7D);
        boot(VAR_PBUS, 4'hF, 4'hF, 4'h0); chk(node_addr, 8'h7E);
        wr(REG_SETADDR, 32'h120); pause(1); chk(node_addr, 8'h20);
        wr(REG_SETADDR, 32'h21); pause(1); chk(node_addr, 8'h20);
        boot(VAR_PBUS, 4'hF, 4'hF, 4'h0); rd(REG_SETADDR); chk(d, 32'h120);
        boot(VAR_PBUS, 4'h1, 4'h0, 4'h0); chk({node_addr, nv_valid}, 9'h020);
        hu <= 4'hA; te <= 4'hB; un <= 4'hC;
        boot(VAR_ECAT, 4'h0, 4'h0, 4'h0); rd(REG_IDENT); chk(d, 32'hABC);
        hu <= 4'h0; te <= 4'h0; un <= 4'h0;
        boot(VAR_ECAT, 4'h0, 4'h0, 4'h0); rd(REG_IDENT); chk(d, 32'h0);
        boot(VAR_PNET, 4'h0, 4'h0, 4'h0);
        wr(REG_CTRL, 32'h5); pause(3); chk(tx_live, 1'b0);
        wr(REG_CTRL, 32'hD); pause(3); chk(tx_live, 1'b1);
        test_done();
    end
endmodule
